// ### src/php_pkg.sv
// php_pkg: constants, types and register map of the parallel host receive port
// assumes a 250 MHz clk, sync active-high reset and a classic wishbone master
// Function
// R1 - port is input (host to device) while port_direction is low
// R2 - port_direction is a latched control bit written from bus bit fourteen
// R3 - input mode: data gate puts latched byte on local bus low byte; code ignores data_gate on reads, returning fifo head or latch
// R4 - output mode: data gate drives latched byte onto host-side data lines
// R5 - host strobe falling captures host data lines into the port latch
// R6 - cpu data write strobe loads bus byte into latch on its falling edge
// R7 - host strobe sets busy flag, driving host busy line active
// R8 - host strobe sets port interrupt request to the processor
// R9 - processor data read gates the byte out and clears the interrupt
// R10 - acknowledge pulse low after read clears busy, telling host byte accepted
// R11 - host presents valid data before asserting strobe
// R12 - processor can read a control port reporting busy state
// R13 - firmware can assert error or paper-end output independently
// R14 - handshake uses exactly fourteen connector lines, others unused
// R15 - host sends next byte only after busy is cleared
// R16 - hardware fault asserts paper-end and error; logical fault only error
// R17 - select line stays asserted while powered
// R18 - reset: input mode, busy, irq, error, paper-end inactive, gate off
package php_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [3:0] PHP_ADDR_DATA    = 4'h0;
  localparam logic [3:0] PHP_ADDR_CONTROL = 4'h4;
  localparam logic [3:0] PHP_ADDR_STATUS  = 4'h8;
  localparam logic [3:0] PHP_ADDR_FAULT   = 4'hC;

  // ****************************************
  // field positions
  // ****************************************
  localparam int PHP_DIR_BIT     = 14;
  localparam int PHP_CTL_ACK     = 0;
  localparam int PHP_CTL_GATE    = 1;
  localparam int PHP_ST_BUSY     = 0;
  localparam int PHP_ST_IRQ      = 1;
  localparam int PHP_ST_DIR      = 2;
  localparam int PHP_ST_FVALID   = 3;
  localparam int PHP_FLT_ERR     = 0;
  localparam int PHP_FLT_PE      = 1;
  localparam int PHP_FLT_HW      = 2;
  localparam int PHP_ST_LVL_LSB  = 8;
  localparam int PHP_HANDSHAKE_LINES = 14;

  // ****************************************
  // timing and sizes
  // ****************************************
  localparam int PHP_CLK_MHZ   = 250;
  localparam int PHP_ACK_NS    = 1000;
  localparam int PHP_ACK_CYC   = (PHP_ACK_NS * PHP_CLK_MHZ) / 1000;
  localparam logic [7:0] PHP_ACK_LAST = 8'(PHP_ACK_CYC - 1);
  localparam int PHP_FIFO_W    = 8;
  localparam int PHP_FIFO_D    = 16;
  localparam logic [7:0] PHP_BYTE_RST = 8'h00;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    PHP_IDLE = 2'b00,
    PHP_HELD = 2'b01,
    PHP_ACK  = 2'b11
  } php_state_e;

  typedef struct packed {
    logic [7:0] data;
    logic       strobe_n;
  } php_host_in_s;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] data_oe_n;
    logic       host_busy_n;
    logic       ack_pulse_n;
    logic       error_out_n;
    logic       paper_end_out;
    logic       select_line;
  } php_host_out_s;

endpackage

// ### src/php_fifo.sv
// php_fifo: synchronous fifo with valid/ready on both sides
// assumes one clock and a sync active-high reset
`timescale 1ns/1ps
module php_fifo
  import php_pkg::*;
#(
  parameter int WIDTH = PHP_FIFO_W,
  parameter int DEPTH = PHP_FIFO_D
)(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign level     = count;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + AW'(1);
      if (pop)
        rd_ptr <= rd_ptr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ### src/php_port.sv
// php_port: parallel host receive port, wishbone register side and host pins
// assumes host pins asynchronous to clk, a classic wishbone master on clk
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module php_port
  import php_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [3:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  // host pins
  input  wire php_host_in_s  host_in,
  output php_host_out_s      host_out,
  // processor interrupt
  output logic               port_irq
);

  // ****************************************
  // host pin synchronisers
  // ****************************************
  php_host_in_s sync1;
  php_host_in_s sync2;
  logic         strobe_d;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1    <= '{data: 8'h00, strobe_n: 1'b1};
      sync2    <= '{data: 8'h00, strobe_n: 1'b1};
      strobe_d <= 1'b1;
    end
    else
    begin
      sync1    <= host_in;
      sync2    <= sync1;
      strobe_d <= sync2.strobe_n;
    end
  end

  wire strobe_fall = strobe_d && !sync2.strobe_n;

  // ****************************************
  // bus decode
  // ****************************************
  wire bus_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr     = bus_req && wb_we_i;
  wire bus_rd     = bus_req && !wb_we_i;
  wire sel_data   = (wb_adr_i == PHP_ADDR_DATA);
  wire sel_ctl    = (wb_adr_i == PHP_ADDR_CONTROL);
  wire sel_status = (wb_adr_i == PHP_ADDR_STATUS);
  wire sel_fault  = (wb_adr_i == PHP_ADDR_FAULT);
  wire wr_data    = bus_wr && sel_data && wb_sel_i[0];
  wire rd_data    = bus_rd && sel_data;
  wire wr_ctl_lo  = bus_wr && sel_ctl && wb_sel_i[0];
  wire wr_ctl_hi  = bus_wr && sel_ctl && wb_sel_i[1];
  wire wr_fault   = bus_wr && sel_fault && wb_sel_i[0];

  // ****************************************
  // state
  // ****************************************
  php_state_e  state;
  php_state_e  next_state;
  logic        port_direction;
  logic [7:0]  port_latch;
  logic        busy_flag;
  logic        irq_flag;
  logic        data_gate;
  logic        fault_err;
  logic        fault_pe;
  logic [7:0]  ack_cnt;
  logic [7:0]  out_drive;

  // ****************************************
  // receive fifo
  // ****************************************
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic [4:0]  fifo_level;

  wire fifo_push = strobe_fall && !port_direction;
  wire fifo_pop  = rd_data && fifo_out_valid;

  php_fifo #(
    .WIDTH (PHP_FIFO_W),
    .DEPTH (PHP_FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (sync2.data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // ****************************************
  // handshake sequencer
  // ****************************************
  wire ack_start = bus_wr && sel_ctl && wb_sel_i[0] && wb_dat_i[PHP_CTL_ACK];
  wire ack_done  = (state == PHP_ACK) && (ack_cnt == PHP_ACK_LAST);

  always_comb
  begin
    next_state = state;
    case (state)
      PHP_IDLE: if (fifo_push) next_state = PHP_HELD;
      PHP_HELD: if (ack_start) next_state = PHP_ACK;
      PHP_ACK:  if (ack_done)  next_state = PHP_IDLE;
      default:  next_state = PHP_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state   <= PHP_IDLE; // see R18
      ack_cnt <= 8'h00;
    end
    else
    begin
      state   <= next_state;
      ack_cnt <= (state == PHP_ACK) ? ack_cnt + 8'h01 : 8'h00;
    end
  end

  // ****************************************
  // latch, flags and control bits
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      port_direction <= 1'b0;         // see R18
      port_latch     <= PHP_BYTE_RST;
      busy_flag      <= 1'b0;
      irq_flag       <= 1'b0;
      data_gate      <= 1'b0;
      fault_err      <= 1'b0;
      fault_pe       <= 1'b0;
    end
    else
    begin
      if (wr_ctl_hi)
        port_direction <= wb_dat_i[PHP_DIR_BIT];         // see R2
      if (wr_ctl_lo)
        data_gate <= wb_dat_i[PHP_CTL_GATE];
      if (fifo_push)
        port_latch <= sync2.data;                        // see R5
      else if (wr_data)
        port_latch <= wb_dat_i[7:0];                     // see R6
      if (fifo_push)
        busy_flag <= 1'b1;                               // see R7
      else if (ack_done)
        busy_flag <= 1'b0;                               // see R10
      if (fifo_push)
        irq_flag <= 1'b1;                                // see R8
      else if (rd_data)
        irq_flag <= 1'b0;                                // see R9
      if (wr_fault)
      begin
        fault_err <= wb_dat_i[PHP_FLT_ERR] | wb_dat_i[PHP_FLT_HW]; // see R13 see R16
        fault_pe  <= wb_dat_i[PHP_FLT_PE] | wb_dat_i[PHP_FLT_HW];  // see R16
      end
    end
  end

  // ****************************************
  // read mux and bus answer
  // ****************************************
  wire [7:0]  rd_byte   = fifo_out_valid ? fifo_out_data : port_latch; // see R3
  wire [31:0] ctl_word  = {17'h00000, port_direction, 12'h000, data_gate, 1'b0};
  wire [31:0] stat_word = {19'h00000, fifo_level, 4'h0, fifo_out_valid,
                           port_direction, irq_flag, busy_flag};      // see R12
  wire [31:0] flt_word  = {30'h00000000, fault_pe, fault_err};
  wire [31:0] next_dat  = sel_data   ? {24'h000000, rd_byte} :
                          sel_ctl    ? ctl_word :
                          sel_status ? stat_word :
                          sel_fault  ? flt_word : 32'h00000000;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_rd ? next_dat : 32'h00000000;
    end
  end

  // ****************************************
  // host side outputs
  // ****************************************
  wire drive_out = port_direction && data_gate;  // see R1 see R4

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      out_drive <= 8'hFF;
      host_out  <= '{data: 8'h00, data_oe_n: 8'hFF, host_busy_n: 1'b1,
                     ack_pulse_n: 1'b1, error_out_n: 1'b1,
                     paper_end_out: 1'b0, select_line: 1'b1};
      port_irq  <= 1'b0;
    end
    else
    begin
      out_drive <= drive_out ? 8'h00 : 8'hFF;
      // thirteen handshake lines leave the port, strobe comes in as the fourteenth; see R14
      host_out  <= '{data: port_latch, data_oe_n: out_drive,
                     host_busy_n: !(busy_flag || !fifo_in_ready),   // see R7 see R15
                     ack_pulse_n: (state != PHP_ACK),               // see R10
                     error_out_n: !fault_err,
                     paper_end_out: fault_pe,
                     select_line: 1'b1};                            // see R17
      port_irq  <= irq_flag;                                        // see R8
    end
  end

endmodule

// ### verif/php_host_model.sv
// php_host_model: host computer side of the byte-wide printer-style port
// assumes the bench calls send and the device busy line is active low
`timescale 1ns/1ps
module php_host_model
  import php_pkg::*;
(
  // clock
  input  wire logic    clk,
  // device pins
  input  wire logic    busy_n,
  output php_host_in_s host_in
);
  initial
  begin
    host_in = '{data: 8'h00, strobe_n: 1'b1};
  end

  // waits for busy clear, presents byte, then strobes
  task automatic send(input logic [7:0] b);
    while (busy_n !== 1'b1)
      @(posedge clk);
    @(posedge clk);
    host_in.data <= b;
    repeat (4) @(posedge clk);
    host_in.strobe_n <= 1'b0;
    repeat (8) @(posedge clk);
    host_in.strobe_n <= 1'b1;
    host_in.data <= ~b;
  endtask
endmodule

// ### verif/php_port_properties.sv
// php_port_properties: concurrent checks on the php_port pins
// assumes bind onto php_port, one clock and sync active-high reset
`timescale 1ns/1ps
module php_port_properties
  import php_pkg::*;
(
  // clock and reset
  input wire logic          clk,
  input wire logic          sys_rst,
  // wishbone
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_we_i,
  input wire logic [3:0]    wb_adr_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  // host pins and irq
  input wire php_host_in_s  host_in,
  input wire php_host_out_s host_out,
  input wire logic          port_irq
);
  logic [8:0] ack_low;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk)
  begin
    if (sys_rst || host_out.ack_pulse_n)
      ack_low <= 9'h000;
    else
      ack_low <= ack_low + 9'h001;
  end
  req_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack missing or too long");
  reset_idle_a: assert property ($fell(sys_rst) |-> host_out.host_busy_n && !port_irq
    && host_out.error_out_n && !host_out.paper_end_out && host_out.data_oe_n == 8'hFF)
    else $error("outputs not idle after reset");
  select_on_a: assert property (host_out.select_line)
    else $error("select line dropped");
  busy_cause_a: assert property ($fell(host_out.host_busy_n) |-> !$past(host_in.strobe_n, 3))
    else $error("busy without strobe");
  busy_irq_a: assert property ($fell(host_out.host_busy_n) |-> port_irq)
    else $error("busy without irq");
  irq_clear_a: assert property ($fell(port_irq) |-> $past(wb_ack_o) && !$past(wb_we_i)
    && $past(wb_adr_i) == PHP_ADDR_DATA)
    else $error("irq cleared without data read");
  ack_width_a: assert property ($rose(host_out.ack_pulse_n) |-> ack_low == 9'(PHP_ACK_CYC))
    else $error("ack pulse width wrong");
  busy_clear_a: assert property ($rose(host_out.ack_pulse_n) |-> $rose(host_out.host_busy_n))
    else $error("busy not cleared after ack");
  cover property ($fell(host_out.host_busy_n));
  cover property ($rose(host_out.ack_pulse_n));
  cover property ($fell(port_irq));
endmodule

bind php_port php_port_properties u_props (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .host_in(host_in),
  .host_out(host_out), .port_irq(port_irq));

// ### verif/php_port_tb.sv
// php_port_tb: self-checking bench for the parallel host receive port
// assumes php_host_model on the host pins, wishbone master in this module
`timescale 1ns/1ps
module php_port_tb
  import php_pkg::*;
;
  logic          clk;
  logic          sys_rst  = 1'b1;
  logic          wb_cyc_i = 1'b0;
  logic          wb_stb_i = 1'b0;
  logic          wb_we_i  = 1'b0;
  logic [3:0]    wb_adr_i = 4'h0;
  logic [3:0]    wb_sel_i = 4'hF;
  logic [31:0]   wb_dat_i = 32'h0;
  logic [31:0]   wb_dat_o;
  logic          wb_ack_o;
  php_host_in_s  host_in;
  php_host_out_s host_out;
  logic          port_irq;
  logic [31:0]   rd;
  int            err_total = 0;
  int            cmp_count = 0;
  int            cycles    = 0;
  php_port DUT (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .host_in(host_in), .host_out(host_out),
    .port_irq(port_irq));
  php_host_model HOST (.clk(clk), .busy_n(host_out.host_busy_n), .host_in(host_in));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: %s %h/%h", $time, msg, seen, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] wd);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do
      @(posedge clk);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // acknowledges the held byte and times the pulse
  task automatic release_byte();
    int lo = 0;
    bus(1'b1, PHP_ADDR_CONTROL, 32'h1);
    repeat (300)
    begin
      @(posedge clk);
      lo += int'(host_out.ack_pulse_n === 1'b0);
    end
    check(32'(lo), 32'(PHP_ACK_CYC), "ack width");
    check(32'(host_out.host_busy_n), 32'h1, "busy clear");
  endtask
  task automatic t_reset();
    check(32'(host_out.data_oe_n), 32'hFF, "oe idle");
    check(32'({host_out.host_busy_n, host_out.error_out_n, port_irq}), 32'h6, "idle");
    bus(1'b0, PHP_ADDR_STATUS, 32'h0);
    check(rd, 32'h0, "status");
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0, "unmapped");
    $display("reset test done");
  endtask
  task automatic t_receive(input logic [7:0] b);
    HOST.send(b);
    check(32'({host_out.host_busy_n, port_irq}), 32'h1, "strobe flags");
    bus(1'b0, PHP_ADDR_STATUS, 32'h0);
    check(rd & 32'h3, 32'h3, "status busy");
    bus(1'b0, PHP_ADDR_DATA, 32'h0);
    check(rd & 32'hFF, 32'(b), "byte");
    @(posedge clk);
    check(32'(port_irq), 32'h0, "irq clear");
    release_byte();
    $display("receive test done");
  endtask
  task automatic t_fifo();
    for (int i = 0; i < PHP_FIFO_D; i++)
    begin
      HOST.send(8'(8'h10 + i));
      if (i < PHP_FIFO_D - 1)
        release_byte();
    end
    check(32'(host_out.host_busy_n), 32'h0, "busy held");
    bus(1'b0, PHP_ADDR_STATUS, 32'h0);
    check(rd & 32'h1F08, 32'h1008, "full level");
    for (int i = 0; i < PHP_FIFO_D; i++)
    begin
      bus(1'b0, PHP_ADDR_DATA, 32'h0);
      check(rd & 32'hFF, 32'(8'h10 + i), "fifo order");
    end
    bus(1'b0, PHP_ADDR_STATUS, 32'h0);
    check(rd & 32'h1F08, 32'h0, "drained");
    release_byte();
    HOST.send(8'hEE);
    bus(1'b0, PHP_ADDR_DATA, 32'h0);
    check(rd & 32'hFF, 32'hEE, "after drain");
    release_byte();
    $display("fifo test done");
  endtask
  task automatic t_dir();
    bus(1'b1, PHP_ADDR_CONTROL, 32'h4002);
    bus(1'b1, PHP_ADDR_DATA, 32'h3C);
    repeat (2) @(posedge clk);
    check(32'({host_out.data_oe_n, host_out.data}), 32'h3C, "drive out");
    HOST.send(8'h77);
    check(32'(host_out.host_busy_n), 32'h1, "strobe ignored");
    bus(1'b1, PHP_ADDR_CONTROL, 32'h2);
    bus(1'b0, PHP_ADDR_DATA, 32'h0);
    check(rd & 32'hFF, 32'h3C, "gate in");
    check(32'(host_out.data_oe_n), 32'hFF, "released");
    $display("direction test done");
  endtask
  task automatic t_fault();
    logic [2:0] code [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    logic [1:0] want [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, PHP_ADDR_FAULT, 32'(code[i]));
      repeat (2) @(posedge clk);
      check(32'({host_out.error_out_n, host_out.paper_end_out}), 32'(want[i]), "fault");
    end
    $display("fault test done");
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_receive(8'hA5);
    t_receive(8'h5A);
    t_fifo();
    t_dir();
    t_fault();
    summarize();
  end
endmodule
